// >>> hdl/abfp_framer.sv
// Block framer, deframer, checksum and Ack/Nak handshake engine for the serial command link
// Behaviour
// - Block: start char, three-digit number, up to 255 chars, end char, checksum.
// - Short message goes in block one, Stx to Etx, then checksum.
// - Long message splits into numbered blocks; full ones end Etb, last ends Etx.
// - Stx is 02, Etx is 03, Etb is 17 hex.
// - Ack 06, Nak 15; result marks '#' 23 success, '!' 21 failure.
// - Control command starts with space, then function code, then parameters.
// - Query command starts with '?', then function code, then parameters.
// - Parameters and data are ASCII hex text of 16-bit signed values.
// - Device answers '#' on success, else '!' plus three-character code.
// - After a complete received block the device sends one Ack or Nak.
// - After Ack the command runs; result goes back as block one with Etx.
// - Two-block response: send block one, wait for Ack, then block two.
// - Checksum starts at FF and XORs every block byte, ends included.
// - In 7-bit mode the checksum top bit is forced to zero.
// - On Nak the sender repeats the frame, at most five times.
`timescale 1ns/100ps
module abfp_framer
   import abfp_pkg::*;
#(
   parameter logic [7:0] BLK_CHARS = abfp_pkg::MSG_MAX,  // Characters per full block
   parameter logic [2:0] RETRIES = abfp_pkg::RETRY_MAX   // Retransmission limit
) (
   input wire logic CLK_SYS,                      // System clock, 20 MHz
   input wire logic NRST,                         // Asynchronous reset, active low
   input wire logic MODE_7BIT,                    // Character length is 7 bits
   input wire abfp_pkg::abfp_rxc_t RX_CHAR,       // Received character from UART layer
   output logic [7:0] TX_DATA,                    // Character to UART layer
   output logic TX_VALID,                         // Character offered
   input wire logic TX_READY,                     // UART layer takes the character
   output logic [7:0] CMD_DATA,                   // Received message character
   output logic CMD_VALID,                        // Message character strobe
   output logic CMD_QUERY,                        // Current command is a query
   output logic CMD_BLOCK_OK,                     // Block passed, Ack queued
   output logic CMD_BLOCK_BAD,                    // Block failed, Nak queued, discard it
   output logic CMD_FRAME_END,                    // Last block of a good frame
   input wire logic RES_VALID,                    // Result request, taken when idle
   input wire logic RES_FAIL,                     // Result is a failure
   input wire logic [23:0] RES_CODE,              // Three failure code characters
   input wire logic [7:0] RSP_DATA,               // Response message character
   input wire logic RSP_VALID,                    // Response character offered
   input wire logic RSP_LAST,                     // Last response character
   output logic RSP_READY,                        // Response character taken
   output logic TX_BUSY,                          // Response engine busy
   output logic TX_DONE,                          // Response frame acknowledged
   output logic TX_FAIL                           // Retries exhausted
);
   import abfp_pkg::*;

   // ==========================================================
   // Helper functions
   // Checksum as sent or compared in the current character length
   function automatic logic [7:0] lrc_fmt(input logic [7:0] v, input logic m7);
      lrc_fmt = m7 ? (v & MASK_7BIT) : v;
   endfunction : lrc_fmt

   // ASCII digit of a block number, position 0 is the hundreds
   function automatic logic [7:0] num_digit(input logic [9:0] n, input logic [1:0] p);
      logic [9:0] q;
      q = (p == 2'h0) ? n / DEC_HUNDRED : (p == 2'h1) ? n / DEC_TEN : n;
      q = q % DEC_TEN;
      num_digit = CH_ZERO + q[7:0];
   endfunction : num_digit

   // ASCII hex digit test
   function automatic logic is_hex(input logic [7:0] c);
      is_hex = (c >= CH_ZERO && c <= CH_NINE) || (c >= CH_UPPER_A && c <= CH_UPPER_F)
         || (c >= CH_LOWER_A && c <= CH_LOWER_F);
   endfunction : is_hex

   // ==========================================================
   // Receive side
   abfp_rxst_t rst_r, rst_nxt;
   logic [7:0] rlrc_r, rlrc_nxt;
   logic [7:0] rlen_r, rlen_nxt;
   logic [9:0] rval_r, rval_nxt;
   logic [9:0] exp_r, exp_nxt;
   logic [1:0] rdig_r, rdig_nxt;
   logic rerr_r, rerr_nxt;
   logic retx_r, retx_nxt;
   logic query_r, query_nxt;
   logic hs_pend_r, hs_pend_nxt;
   logic [7:0] hs_char_r, hs_char_nxt;

   // Decoded receive events
   wire logic [7:0] rc = RX_CHAR.data;
   wire logic rv = RX_CHAR.valid;
   wire logic is_digit = rc >= CH_ZERO && rc <= CH_NINE;
   wire logic [9:0] dval = 10'(rval_r * DEC_TEN + {2'h0, rc - CH_ZERO});
   wire logic is_end = rc == CH_ETX || rc == CH_ETB;
   wire logic msg_chr = rv && rst_r == R_MSG && !is_end;
   wire logic first_blk = exp_r == BLK_FIRST;
   wire logic pfx_ok = rc == CH_PFX_CTRL || rc == CH_PFX_QUERY;
   wire logic chr_bad = (first_blk && rlen_r == POS_PREFIX) ? !pfx_ok
      : (first_blk && rlen_r == POS_FUNC) ? 1'b0 : !is_hex(rc);
   wire logic blk_done = rv && rst_r == R_LRC;
   wire logic blk_good = !rerr_r && !RX_CHAR.perr
      && lrc_fmt(rlrc_r, MODE_7BIT) == lrc_fmt(rc, MODE_7BIT);
   wire logic host_ack = rv && rst_r == R_HUNT && !RX_CHAR.perr && rc == CH_ACK;
   wire logic host_nak = rv && rst_r == R_HUNT && !RX_CHAR.perr && rc == CH_NAK;
   logic hs_go;

   // Receive state and block checks
   always_comb begin
      rst_nxt = rst_r;
      rlrc_nxt = rv ? rlrc_r ^ rc : rlrc_r;
      rlen_nxt = rlen_r;
      rval_nxt = rval_r;
      exp_nxt = exp_r;
      rdig_nxt = rdig_r;
      rerr_nxt = rerr_r || (rv && RX_CHAR.perr);
      retx_nxt = retx_r;
      query_nxt = query_r;
      case (rst_r)
         R_HUNT: begin
            if (rv && rc == CH_STX) begin
               rst_nxt = R_NUM;
               rlrc_nxt = LRC_INIT ^ CH_STX;
               rerr_nxt = RX_CHAR.perr;
               rval_nxt = 10'h000;
               rdig_nxt = 2'h0;
               rlen_nxt = 8'h00;
            end
         end
         R_NUM: begin
            if (rv) begin
               rval_nxt = dval;
               rdig_nxt = rdig_r + 2'h1;
               if (!is_digit) rerr_nxt = 1'b1;
               if (rdig_r == NUM_LAST) begin
                  rst_nxt = R_MSG;
                  if (dval != exp_r) rerr_nxt = 1'b1;
               end
            end
         end
         R_MSG: begin
            if (rv && is_end) begin
               rst_nxt = R_LRC;
               retx_nxt = rc == CH_ETX;
            end else if (msg_chr) begin
               rlen_nxt = rlen_r + 8'h01;
               if (rlen_r == BLK_CHARS || chr_bad) rerr_nxt = 1'b1;
               if (first_blk && rlen_r == POS_PREFIX) query_nxt = rc == CH_PFX_QUERY;
            end
         end
         R_LRC: begin
            if (rv) begin
               rst_nxt = R_HUNT;
               if (blk_good) exp_nxt = retx_r ? BLK_FIRST : exp_r + 10'h001;
            end
         end
         default: rst_nxt = R_HUNT;
      endcase
   end

   // One Ack or Nak per finished block; a new block wins over the send clearing it
   assign hs_pend_nxt = blk_done ? 1'b1 : (hs_go ? 1'b0 : hs_pend_r);
   assign hs_char_nxt = blk_done ? (blk_good ? CH_ACK : CH_NAK) : hs_char_r;

   // Receive registers
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         rst_r <= R_HUNT;
         rlrc_r <= LRC_INIT;
         rlen_r <= 8'h00;
         rval_r <= 10'h000;
         exp_r <= BLK_FIRST;
         rdig_r <= 2'h0;
         {rerr_r, retx_r, query_r, hs_pend_r} <= 4'h0;
         hs_char_r <= CH_NAK;
      end else begin
         rst_r <= rst_nxt;
         rlrc_r <= rlrc_nxt;
         rlen_r <= rlen_nxt;
         rval_r <= rval_nxt;
         exp_r <= exp_nxt;
         rdig_r <= rdig_nxt;
         {rerr_r, retx_r, query_r, hs_pend_r} <= {rerr_nxt, retx_nxt, query_nxt, hs_pend_nxt};
         hs_char_r <= hs_char_nxt;
      end
   end

   // Command stream outputs toward the application
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         CMD_DATA <= 8'h00;
         {CMD_VALID, CMD_QUERY, CMD_BLOCK_OK, CMD_BLOCK_BAD, CMD_FRAME_END} <= 5'h00;
      end else begin
         CMD_DATA <= msg_chr ? rc : CMD_DATA;
         CMD_VALID <= msg_chr;
         CMD_QUERY <= query_nxt;
         CMD_BLOCK_OK <= blk_done && blk_good;
         CMD_BLOCK_BAD <= blk_done && !blk_good;
         CMD_FRAME_END <= blk_done && blk_good && retx_r;
      end
   end

   // ==========================================================
   // Transmit side
   abfp_txst_t tst_r, tst_nxt;
   logic [7:0] buf_mem [0:255];
   logic [7:0] tlen_r, tlen_nxt;
   logic [7:0] tidx_r, tidx_nxt;
   logic [9:0] tblk_r, tblk_nxt;
   logic [7:0] tlrc_r;
   logic [2:0] retry_r, retry_nxt;
   logic tlast_r, tlast_nxt;
   logic res_mode_r, res_mode_nxt;
   logic [31:0] res_r;
   logic [7:0] fr_byte;

   // Launch decisions; handshakes only go out while no frame character of a block is being sent
   wire logic tx_free = !TX_VALID;
   wire logic sending = tst_r inside {T_STX, T_NUM, T_MSG, T_END, T_LRC};
   assign hs_go = hs_pend_r && tx_free && !sending;
   wire logic fr_go = tx_free && sending;
   wire logic rsp_take = RSP_VALID && RSP_READY;
   wire logic [31:0] res_chars = RES_FAIL ? {CH_RES_FAIL, RES_CODE} : {CH_RES_OK, 24'h000000};
   wire logic [7:0] res_byte = res_r[31 - 8 * tidx_r[1:0] -: 8];
   wire logic [7:0] msg_byte = res_mode_r ? res_byte : buf_mem[tidx_r];

   // Byte currently placed into the frame
   always_comb begin
      case (tst_r)
         T_STX: fr_byte = CH_STX;
         T_NUM: fr_byte = num_digit(tblk_r, tidx_r[1:0]);
         T_MSG: fr_byte = msg_byte;
         T_END: fr_byte = tlast_r ? CH_ETX : CH_ETB;
         T_LRC: fr_byte = lrc_fmt(tlrc_r, MODE_7BIT);
         default: fr_byte = 8'h00;
      endcase
   end

   // Transmit sequencing: fill, frame, wait for the host's answer
   always_comb begin
      tst_nxt = tst_r;
      tlen_nxt = tlen_r;
      tidx_nxt = tidx_r;
      tblk_nxt = tblk_r;
      retry_nxt = retry_r;
      tlast_nxt = tlast_r;
      res_mode_nxt = res_mode_r;
      case (tst_r)
         T_IDLE: begin
            tblk_nxt = BLK_FIRST;
            retry_nxt = 3'h0;
            tlen_nxt = 8'h00;
            if (RES_VALID) begin
               tst_nxt = T_STX;
               res_mode_nxt = 1'b1;
               tlast_nxt = 1'b1;
               tlen_nxt = RES_FAIL ? RES_FAIL_LEN : RES_OK_LEN;
            end else if (RSP_VALID) begin
               tst_nxt = T_FILL;
               res_mode_nxt = 1'b0;
            end
         end
         T_FILL: begin
            if (rsp_take) begin
               tlen_nxt = tlen_r + 8'h01;
               if (RSP_LAST || tlen_r + 8'h01 == BLK_CHARS) begin
                  tst_nxt = T_STX;
                  tlast_nxt = RSP_LAST;
               end
            end
         end
         T_STX: if (fr_go) begin
            tst_nxt = T_NUM;
            tidx_nxt = 8'h00;
         end
         T_NUM: if (fr_go) begin
            tidx_nxt = tidx_r + 8'h01;
            if (tidx_r[1:0] == NUM_LAST) begin
               tidx_nxt = 8'h00;
               tst_nxt = tlen_r == 8'h00 ? T_END : T_MSG;
            end
         end
         T_MSG: if (fr_go) begin
            tidx_nxt = tidx_r + 8'h01;
            if (tidx_r + 8'h01 == tlen_r) tst_nxt = T_END;
         end
         T_END: if (fr_go) tst_nxt = T_LRC;
         T_LRC: if (fr_go) tst_nxt = T_WAIT;
         T_WAIT: begin
            if (host_nak) begin
               if (retry_r == RETRIES) tst_nxt = T_IDLE;
               else begin
                  retry_nxt = retry_r + 3'h1;
                  tst_nxt = T_STX;
               end
            end else if (host_ack) begin
               retry_nxt = 3'h0;
               tlen_nxt = 8'h00;
               tblk_nxt = tblk_r + 10'h001;
               tst_nxt = tlast_r ? T_IDLE : T_FILL;
            end
         end
         default: tst_nxt = T_IDLE;
      endcase
   end

   // Transmit registers
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         tst_r <= T_IDLE;
         tlen_r <= 8'h00;
         tidx_r <= 8'h00;
         tblk_r <= BLK_FIRST;
         retry_r <= 3'h0;
         {tlast_r, res_mode_r} <= 2'h0;
         res_r <= 32'h00000000;
      end else begin
         tst_r <= tst_nxt;
         tlen_r <= tlen_nxt;
         tidx_r <= tidx_nxt;
         tblk_r <= tblk_nxt;
         retry_r <= retry_nxt;
         {tlast_r, res_mode_r} <= {tlast_nxt, res_mode_nxt};
         res_r <= (tst_r == T_IDLE && RES_VALID) ? res_chars : res_r;
      end
   end

   // Block buffer, kept whole so a Nak can replay it
   always_ff @(posedge CLK_SYS) begin
      if (rsp_take) buf_mem[tlen_r] <= RSP_DATA;
   end

   // Running checksum of the outgoing block
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) tlrc_r <= LRC_INIT;
      else if (fr_go && tst_r == T_STX) tlrc_r <= LRC_INIT ^ CH_STX;
      else if (fr_go && tst_r != T_LRC) tlrc_r <= tlrc_r ^ fr_byte;
   end

   // Character port and status outputs
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         TX_DATA <= 8'h00;
         {TX_VALID, RSP_READY, TX_BUSY, TX_DONE, TX_FAIL} <= 5'h00;
      end else begin
         TX_DATA <= hs_go ? hs_char_r : (fr_go ? fr_byte : TX_DATA);
         TX_VALID <= hs_go || fr_go || (TX_VALID && !TX_READY);
         RSP_READY <= tst_nxt == T_FILL && !(tst_r == T_FILL && rsp_take && tst_nxt != T_FILL);
         TX_BUSY <= tst_nxt != T_IDLE;
         TX_DONE <= tst_r == T_WAIT && host_ack && tlast_r;
         TX_FAIL <= tst_r == T_WAIT && host_nak && retry_r == RETRIES;
      end
   end
endmodule : abfp_framer

// >>> hdl/abfp_pkg.sv
// Constants, carriers and state types of the ASCII block frame protocol engine
package abfp_pkg;
   // ==========================================================
   // Framing and handshake characters
   localparam logic [7:0] CH_STX = 8'h02;        // Block start
   localparam logic [7:0] CH_ETX = 8'h03;        // Frame end
   localparam logic [7:0] CH_ETB = 8'h17;        // Block end, more blocks follow
   localparam logic [7:0] CH_ACK = 8'h06;        // Acknowledge
   localparam logic [7:0] CH_NAK = 8'h15;        // Not acknowledge
   localparam logic [7:0] CH_RES_OK = 8'h23;     // Application success
   localparam logic [7:0] CH_RES_FAIL = 8'h21;   // Application failure
   localparam logic [7:0] CH_PFX_CTRL = 8'h20;   // Control command prefix
   localparam logic [7:0] CH_PFX_QUERY = 8'h3f;  // Query command prefix
   localparam logic [7:0] CH_ZERO = 8'h30;       // ASCII zero
   localparam logic [7:0] CH_NINE = 8'h39;       // ASCII nine
   localparam logic [7:0] CH_UPPER_A = 8'h41;    // ASCII A
   localparam logic [7:0] CH_UPPER_F = 8'h46;    // ASCII F
   localparam logic [7:0] CH_LOWER_A = 8'h61;    // ASCII a
   localparam logic [7:0] CH_LOWER_F = 8'h66;    // ASCII f

   // ==========================================================
   // Checksum and block layout
   localparam logic [7:0] LRC_INIT = 8'hff;      // Checksum seed
   localparam logic [7:0] MASK_7BIT = 8'h7f;     // Clears the top bit in 7-bit mode
   localparam logic [7:0] MSG_MAX = 8'hff;       // Message characters per block
   localparam logic [1:0] NUM_LAST = 2'h2;       // Index of the last block number digit
   localparam logic [9:0] BLK_FIRST = 10'h001;   // Number of the first block
   localparam logic [9:0] DEC_TEN = 10'h00a;     // Decimal base
   localparam logic [9:0] DEC_HUNDRED = 10'h064; // Hundreds weight
   localparam logic [7:0] POS_PREFIX = 8'h00;    // Prefix position in the first block
   localparam logic [7:0] POS_FUNC = 8'h01;      // Function code position
   localparam logic [7:0] RES_FAIL_LEN = 8'h04;  // Failure mark plus three code chars
   localparam logic [7:0] RES_OK_LEN = 8'h01;    // Success mark alone
   localparam logic [2:0] RETRY_MAX = 3'h5;      // Retransmissions after Nak

   // ==========================================================
   // Carriers and states
   typedef struct packed {
      logic valid;      // Character present this cycle
      logic perr;       // Parity error flagged by the character layer
      logic [7:0] data; // Character
   } abfp_rxc_t;

   typedef enum logic [1:0] {R_HUNT, R_NUM, R_MSG, R_LRC} abfp_rxst_t;
   typedef enum logic [2:0] {T_IDLE, T_FILL, T_STX, T_NUM, T_MSG, T_END, T_LRC, T_WAIT}
      abfp_txst_t;
endpackage : abfp_pkg

// >>> verif/abfp_framer_chk_sva.sv
// Port checker for the block framer, bound from the bench
`timescale 1ns/100ps
module abfp_framer_chk (
   input wire logic CLK_SYS, // System clock
   input wire logic NRST, // Reset, active low
   input wire logic [7:0] TX_DATA, // Character offered
   input wire logic TX_VALID, // Character valid
   input wire logic TX_READY, // Character taken
   input wire logic CMD_BLOCK_OK, // Good block pulse
   input wire logic CMD_BLOCK_BAD, // Bad block pulse
   input wire logic CMD_FRAME_END, // Frame end pulse
   input wire logic RES_VALID, // Result request
   input wire logic RSP_READY, // Response char taken
   input wire logic TX_BUSY, // Response engine busy
   input wire logic TX_DONE, // Frame acknowledged
   input wire logic TX_FAIL // Retries exhausted
);
   import abfp_pkg::*;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   // ==========================================================
   // Transmit side
   a_tx_char_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
      else $error("TX char dropped or changed before it was taken");
   a_tx_one_bubble: assert property (TX_VALID && TX_READY |=> !TX_VALID)
      else $error("TX char launched without a bubble");
   a_res_opens_stx: assert property ($rose(RES_VALID) && !TX_BUSY |-> ##2 (TX_VALID && TX_DATA == CH_STX))
      else $error("Result frame did not open with the start char");
   a_done_goes_idle: assert property (TX_DONE || TX_FAIL |-> !TX_BUSY)
      else $error("Engine busy after frame ended");
   a_done_fail_excl: assert property (!(TX_DONE && TX_FAIL))
      else $error("Done and fail together");
   a_rsp_only_busy: assert property (RSP_READY |-> TX_BUSY)
      else $error("Response char taken while idle");
   // ==========================================================
   // Receive side
   a_ok_sends_ack: assert property (CMD_BLOCK_OK |-> ##[1:1000] (TX_VALID && TX_DATA == CH_ACK))
      else $error("Good block not answered with Ack");
   a_bad_sends_nak: assert property (CMD_BLOCK_BAD |-> ##[1:1000] (TX_VALID && TX_DATA == CH_NAK))
      else $error("Bad block not answered with Nak");
   a_end_needs_ok: assert property (CMD_FRAME_END |-> CMD_BLOCK_OK && !CMD_BLOCK_BAD)
      else $error("Frame end without a good block");
   c_frame_end: cover property (CMD_FRAME_END);
   c_bad_block: cover property (CMD_BLOCK_BAD);
   c_tx_done: cover property (TX_DONE);
   c_tx_fail: cover property (TX_FAIL);
endmodule : abfp_framer_chk

// >>> verif/abfp_host.sv
// Host computer model: sends characters to the device and takes its replies
`timescale 1ns/100ps
module abfp_host (
   input wire logic clk, // System clock
   input wire logic nrst, // Reset, active low
   input wire logic tx_valid, // Device offers a char
   output logic tx_ready, // Host takes the char
   output abfp_pkg::abfp_rxc_t rx_char // Char towards the device
);
   import abfp_pkg::*;
   logic [8:0] outq[$];
   int seed = 32'hf3da53eb;
   // Queue a char with its parity flag for sending
   task automatic put(input logic [7:0] c, input logic perr);
      outq.push_back({perr, c});
   endtask : put
   // Chars go out back to back; idle data toggles so no stale value lingers
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_ready <= 1'b0;
         rx_char <= '0;
      end else begin
         tx_ready <= ($random(seed) & 3) != 0; // Random stalls on the device's sender
         if (outq.size() != 0) begin
            {rx_char.perr, rx_char.data} <= outq.pop_front();
            rx_char.valid <= 1'b1;
         end else begin
            rx_char.valid <= 1'b0;
            rx_char.perr <= 1'b0;
            rx_char.data <= ~rx_char.data;
         end
      end
   end
endmodule : abfp_host

// >>> verif/tb_top.sv
// Self-checking bench for the block framer with a host model
`timescale 1ns/100ps
module tb_top;
   import abfp_pkg::*;
   localparam logic [7:0] BLK = 8'h08;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic mode_7bit = 1'b0;
   abfp_pkg::abfp_rxc_t rx_char;
   logic [7:0] tx_data, cmd_data, rsp_data = 8'h00;
   logic tx_valid, tx_ready, cmd_valid, cmd_query, cmd_ok, cmd_bad, cmd_end;
   logic res_valid = 1'b0, res_fail = 1'b0, rsp_valid = 1'b0, rsp_last = 1'b0;
   logic [23:0] res_code = 24'h303030;
   logic rsp_ready, tx_busy, tx_done, tx_fail;
   logic [7:0] exp_tx[$], exp_cmd[$], exp_blk[$], exp_end[$], m[$], rq[$];
   int mismatches = 0, comparisons = 0, seed = 32'hf3da53eb;
   bit cmd_chk = 1'b1;
   abfp_framer #(.BLK_CHARS(BLK), .RETRIES(RETRY_MAX)) dut (.CLK_SYS(clk_sys), .NRST(nrst),
      .MODE_7BIT(mode_7bit), .RX_CHAR(rx_char), .TX_DATA(tx_data), .TX_VALID(tx_valid),
      .TX_READY(tx_ready), .CMD_DATA(cmd_data), .CMD_VALID(cmd_valid), .CMD_QUERY(cmd_query),
      .CMD_BLOCK_OK(cmd_ok), .CMD_BLOCK_BAD(cmd_bad), .CMD_FRAME_END(cmd_end),
      .RES_VALID(res_valid), .RES_FAIL(res_fail), .RES_CODE(res_code), .RSP_DATA(rsp_data),
      .RSP_VALID(rsp_valid), .RSP_LAST(rsp_last), .RSP_READY(rsp_ready), .TX_BUSY(tx_busy),
      .TX_DONE(tx_done), .TX_FAIL(tx_fail));
   abfp_host host (.clk(clk_sys), .nrst(nrst), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_char(rx_char));
   // Clock, 50 ns period
   always #25 clk_sys = ~clk_sys;
   // ==========================================================
   // Helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic complete_run;
      if (mismatches == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   function automatic logic [7:0] hexc(input logic [3:0] v);
      return (v < 4'ha) ? CH_ZERO + {4'h0, v} : CH_UPPER_A + {4'h0, v} - 8'h0a;
   endfunction : hexc
   // Build a block; to the device through the host, or as expected device output
   task automatic blk(input logic [9:0] num, input logic [7:0] msg[$], input logic [7:0] e,
      input bit to_dev, input int flaw);
      logic [7:0] b[$];
      logic [7:0] l;
      b = {CH_STX, CH_ZERO + 8'(num / 100), CH_ZERO + 8'((num / 10) % 10), CH_ZERO + 8'(num % 10)};
      b = {b, msg, e};
      l = LRC_INIT;
      foreach (b[i]) l ^= b[i];
      if (mode_7bit) l &= MASK_7BIT;
      if (flaw == 1) l = ~l;
      b.push_back(l);
      foreach (b[i])
         if (to_dev) host.put(b[i], flaw == 2 && i == 5);
         else exp_tx.push_back(b[i]);
      if (to_dev && cmd_chk) exp_cmd = {exp_cmd, msg};
   endtask : blk
   task automatic drain;
      int n;
      n = 0;
      while (exp_tx.size() + exp_cmd.size() + exp_blk.size() + exp_end.size() + host.outq.size()
         != 0 && n < 3000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 3000) check(8'h00, 8'h01);
      repeat (4) @(posedge clk_sys);
   endtask : drain
   task automatic res(input logic fail);
      @(posedge clk_sys);
      res_valid <= 1'b1;
      res_fail <= fail;
      @(posedge clk_sys);
      res_valid <= 1'b0;
   endtask : res
   task automatic rsp_send(input logic [7:0] q[$]);
      foreach (q[i]) begin
         rsp_data <= q[i];
         rsp_valid <= 1'b1;
         rsp_last <= (i == q.size() - 1);
         do @(posedge clk_sys); while (rsp_ready !== 1'b1);
      end
      rsp_valid <= 1'b0;
   endtask : rsp_send
   // Monitor: each result seen takes the oldest expectation
   always @(posedge clk_sys) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         check(tx_data, exp_tx.size() ? exp_tx.pop_front() : 8'hxx);
      if (cmd_valid === 1'b1 && cmd_chk)
         check(cmd_data, exp_cmd.size() ? exp_cmd.pop_front() : 8'hxx);
      if (cmd_ok === 1'b1 || cmd_bad === 1'b1)
         check({4'h0, cmd_ok & cmd_query, cmd_end, cmd_bad, cmd_ok},
            exp_blk.size() ? exp_blk.pop_front() : 8'hxx);
      if (tx_done === 1'b1 || tx_fail === 1'b1)
         check({6'h0, tx_fail, tx_done}, exp_end.size() ? exp_end.pop_front() : 8'hxx);
   end
   // Watchdog
   initial begin
      repeat (60000) @(posedge clk_sys);
      mismatches++;
      complete_run();
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      mode_7bit <= 1'($random(seed));
      @(posedge clk_sys);
      host.put(8'h41, 1'b0); // Stray char before the start char is dropped
      m = {CH_PFX_CTRL, 8'h53, hexc(4'(($random(seed)))), hexc(4'h2), hexc(4'hf), hexc(4'ha)};
      blk(1, m, CH_ETX, 1, 0);
      exp_blk.push_back(8'h05);
      exp_tx.push_back(CH_ACK);
      drain();
      blk(1, {CH_RES_OK}, CH_ETX, 0, 0);
      res(1'b0);
      drain();
      host.put(CH_ACK, 1'b0);
      exp_end.push_back(8'h01);
      drain();
      // Faulty blocks: bad sum, parity, prefix, non-hex, number
      cmd_chk = 1'b0;
      for (int f = 1; f <= 5; f++) begin
         m = {(f == 3) ? 8'h58 : CH_PFX_QUERY, 8'h51, (f == 4) ? 8'h47 : hexc(4'h3), hexc(4'h9)};
         blk((f == 5) ? 10'h002 : 10'h001, m, CH_ETX, 1, f);
         exp_blk.push_back(8'h02);
         exp_tx.push_back(CH_NAK);
         drain();
      end
      cmd_chk = 1'b1;
      // Two-block query command; host waits for Ack before block two
      m = {CH_PFX_QUERY, 8'h51};
      repeat (6) m.push_back(hexc(4'($random(seed))));
      blk(1, m, CH_ETB, 1, 0);
      exp_blk.push_back(8'h09);
      exp_tx.push_back(CH_ACK);
      drain();
      m = {hexc(4'h1), hexc(4'hb), hexc(4'he)};
      blk(2, m, CH_ETX, 1, 0);
      exp_blk.push_back(8'h0d);
      exp_tx.push_back(CH_ACK);
      drain();
      // Response stream split in two blocks, 7-bit characters
      mode_7bit <= 1'b1;
      @(posedge clk_sys);
      rq = {};
      repeat (10) rq.push_back(8'($random(seed)) & MASK_7BIT);
      fork
         rsp_send(rq);
      join_none
      blk(1, rq[0:7], CH_ETB, 0, 0);
      drain();
      host.put(CH_ACK, 1'b0);
      blk(2, rq[8:9], CH_ETX, 0, 0);
      drain();
      host.put(CH_ACK, 1'b0);
      exp_end.push_back(8'h01);
      drain();
      // Failure result, host keeps refusing
      res_code <= {hexc(4'h0), hexc(4'h4), hexc(4'($random(seed)))};
      @(posedge clk_sys);
      for (int i = 0; i <= 5; i++) begin
         blk(1, {CH_RES_FAIL, res_code[23:16], res_code[15:8], res_code[7:0]}, CH_ETX, 0, 0);
         if (i == 0) res(1'b1);
         drain();
         if (i == 2) res(1'b0); // Ignored while busy
         host.put(CH_NAK, 1'b0);
      end
      exp_end.push_back(8'h02);
      drain();
      complete_run();
   end
endmodule : tb_top
bind abfp_framer abfp_framer_chk chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .TX_DATA(TX_DATA),
   .TX_VALID(TX_VALID), .TX_READY(TX_READY), .CMD_BLOCK_OK(CMD_BLOCK_OK),
   .CMD_BLOCK_BAD(CMD_BLOCK_BAD), .CMD_FRAME_END(CMD_FRAME_END), .RES_VALID(RES_VALID),
   .RSP_READY(RSP_READY), .TX_BUSY(TX_BUSY), .TX_DONE(TX_DONE), .TX_FAIL(TX_FAIL));
